// [hdl/rtal_defs.svh]
// Constants for the terminal address latch and status output block
`ifndef RTAL_DEFS_SVH
`define RTAL_DEFS_SVH
// ==========================================================
// Register byte offsets
`define RTAL_CFG4_OFS 12'h010
`define RTAL_CFG5_OFS 12'h014
`define RTAL_CFG6_OFS 12'h018
`define RTAL_CFG7_OFS 12'h01C
`define RTAL_STAT_OFS 12'h020
// ==========================================================
// Field positions
`define RTAL_LATEN_BIT 3
`define RTAL_SRC_BIT 5
`define RTAL_PULSE_SEL_BIT 0
// ==========================================================
// Reset values and timing
`define RTAL_CFG_RST 1'b0
`define RTAL_ADDR_RST 6'h00
`define RTAL_PULSE_CYC 2'h2
`endif

// [hdl/rtal_pkg.sv]
// Types for the terminal address latch and status output block
package rtal_pkg;
   typedef enum logic [1:0] {RTAL_TRACK, RTAL_HELD, RTAL_SOFT} rtal_mode_e;
   typedef logic [5:0] rtal_addr_t;
endpackage

// [hdl/rtal_sync.sv]
// Two flip-flop synchroniser, one per bit
`timescale 1ns/10ps
module rtal_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule

// [hdl/rtal_top.sv]
// Terminal address latch and shared status output with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "rtal_defs.svh"
module rtal_top (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [4:0] terminal_address_straps,
   input wire logic terminal_address_parity_strap,
   input wire logic terminal_address_latch_pin,
   input wire logic message_active,
   input wire logic terminal_mode,
   input wire logic reset_cmd_rx,
   output logic [5:0] terminal_address_ff,
   output logic status_out_n_ff
);
   // ==========================================================
   // Pin synchronisers
   logic [6:0] pins_sync;
   logic latch_q_ff;
   logic latch_rise;
   rtal_sync #(.WIDTH(7)) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in({terminal_address_latch_pin, terminal_address_parity_strap,
                 terminal_address_straps}),
      .sync_out(pins_sync)
   );
   wire logic [5:0] strap_word = {pins_sync[4:0], pins_sync[5]};
   wire logic latch_lvl = pins_sync[6];
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_q_ff <= 1'b0;
      end else begin
         latch_q_ff <= latch_lvl;
      end
   end
   assign latch_rise = latch_lvl & ~latch_q_ff;
   // ==========================================================
   // AHB-Lite slave
   logic wr_pend_ff;
   logic [11:0] wr_addr_ff;
   logic host_address_write_enable_ff;
   logic address_source_select_ff;
   logic pulse_sel_ff;
   logic [5:0] host_addr_ff;
   logic soft_latched_ff;
   wire logic take = hsel & hready & htrans[1];
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
      end else begin
         wr_pend_ff <= take & hwrite;
         wr_addr_ff <= haddr;
      end
   end
   wire logic wr_cfg5 = wr_pend_ff && (wr_addr_ff == `RTAL_CFG5_OFS);
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_address_write_enable_ff <= `RTAL_CFG_RST;
         address_source_select_ff <= `RTAL_CFG_RST;
         pulse_sel_ff <= `RTAL_CFG_RST;
         host_addr_ff <= `RTAL_ADDR_RST;
      end else if (wr_pend_ff) begin
         case (wr_addr_ff)
            `RTAL_CFG4_OFS: begin
               host_address_write_enable_ff <= hwdata[`RTAL_LATEN_BIT];
            end
            `RTAL_CFG5_OFS: begin
               if (host_address_write_enable_ff) begin
                  host_addr_ff <= hwdata[5:0];
               end
            end
            `RTAL_CFG6_OFS: begin
               address_source_select_ff <= hwdata[`RTAL_SRC_BIT];
            end
            `RTAL_CFG7_OFS: begin
               pulse_sel_ff <= hwdata[`RTAL_PULSE_SEL_BIT];
            end
            default: begin
            end
         endcase
      end
   end
   // Host address counts only once actually written in software mode
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         soft_latched_ff <= 1'b0;
      end else if (!address_source_select_ff) begin
         soft_latched_ff <= 1'b0;
      end else if (wr_cfg5 && host_address_write_enable_ff) begin
         soft_latched_ff <= 1'b1;
      end
   end
   // Read data is registered, so every access takes one wait-free phase
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (haddr)
         `RTAL_CFG4_OFS: nxt_rdata[`RTAL_LATEN_BIT] =
            host_address_write_enable_ff;
         `RTAL_CFG5_OFS: nxt_rdata[5:0] = host_addr_ff;
         `RTAL_CFG6_OFS: nxt_rdata[`RTAL_SRC_BIT] = address_source_select_ff;
         `RTAL_CFG7_OFS: nxt_rdata[`RTAL_PULSE_SEL_BIT] = pulse_sel_ff;
         `RTAL_STAT_OFS: nxt_rdata[5:0] = terminal_address_ff;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (take && !hwrite) begin
            hrdata <= nxt_rdata;
         end
      end
   end
   // ==========================================================
   // Terminal address selection
   rtal_pkg::rtal_mode_e mode;
   always_comb begin
      if (!latch_lvl) begin
         mode = rtal_pkg::RTAL_TRACK;
      end else if (address_source_select_ff) begin
         mode = rtal_pkg::RTAL_SOFT;
      end else begin
         mode = rtal_pkg::RTAL_HELD;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         terminal_address_ff <= `RTAL_ADDR_RST;
      end else begin
         case (mode)
            rtal_pkg::RTAL_TRACK: terminal_address_ff <= strap_word;
            rtal_pkg::RTAL_HELD: begin
               if (latch_rise) begin
                  terminal_address_ff <= strap_word;
               end
            end
            rtal_pkg::RTAL_SOFT: begin
               if (soft_latched_ff) begin
                  terminal_address_ff <= host_addr_ff;
               end
            end
            default: terminal_address_ff <= strap_word;
         endcase
      end
   end
   // ==========================================================
   // Shared status output
   logic cmd_q_ff;
   logic [1:0] pulse_cnt_ff;
   wire logic cmd_rise = reset_cmd_rx & ~cmd_q_ff;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q_ff <= 1'b0;
         pulse_cnt_ff <= 2'h0;
      end else begin
         cmd_q_ff <= reset_cmd_rx;
         // The edge cycle itself drives low, so the count holds the rest
         if (cmd_rise && terminal_mode) begin
            pulse_cnt_ff <= `RTAL_PULSE_CYC - 2'h1;
         end else if (pulse_cnt_ff != 2'h0) begin
            pulse_cnt_ff <= pulse_cnt_ff - 2'h1;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_out_n_ff <= 1'b1;
      end else if (pulse_sel_ff) begin
         status_out_n_ff <= !(pulse_cnt_ff != 2'h0 ||
                              (cmd_rise && terminal_mode));
      end else begin
         status_out_n_ff <= !message_active;
      end
   end
   // ==========================================================
   // Checks
   property p_track;
      @(posedge ref_clk) disable iff (!reset_n)
      !latch_lvl |=> terminal_address_ff == $past(strap_word);
   endproperty
   a_track: assert property (p_track) else $error("track failed");
   property p_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      (latch_lvl && !latch_rise && !address_source_select_ff) |=>
         $stable(terminal_address_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("hold failed");
   property p_soft;
      @(posedge ref_clk) disable iff (!reset_n)
      (latch_lvl && address_source_select_ff && soft_latched_ff) |=>
         terminal_address_ff == $past(host_addr_ff);
   endproperty
   a_soft: assert property (p_soft) else $error("soft failed");
   property p_msg;
      @(posedge ref_clk) disable iff (!reset_n)
      !pulse_sel_ff |=> status_out_n_ff == !$past(message_active);
   endproperty
   a_msg: assert property (p_msg) else $error("msg failed");
   property p_pulse;
      @(posedge ref_clk) disable iff (!reset_n)
      (pulse_sel_ff && cmd_rise && terminal_mode && pulse_cnt_ff == 2'h0)
         |=> !status_out_n_ff ##1 !status_out_n_ff;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse failed");
   property p_pulse_end;
      @(posedge ref_clk) disable iff (!reset_n)
      (pulse_sel_ff && pulse_cnt_ff == 2'h0 && !(cmd_rise && terminal_mode))
         |=> status_out_n_ff;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
endmodule

// [test/rtal_strap_board.sv]
// Board strap model driving the address straps and the latch pin
`timescale 1ns/10ps
module rtal_strap_board (
   input wire logic ref_clk,
   input wire logic [5:0] strap_val,
   input wire logic latch_req,
   output logic [4:0] straps,
   output logic parity,
   output logic latch_pin
);
   // ==========================================================
   // Strap levels
   // Straps are resistors on the board, so they always show a level
   assign straps = strap_val[5:1];
   assign parity = strap_val[0];
   // Latch pin moves only after a clock edge, so it never glitches
   always_ff @(posedge ref_clk) begin
      latch_pin <= latch_req;
   end
endmodule

// [test/tb_top.sv]
// Testbench for the terminal address latch and status output block
`timescale 1ns/10ps
`include "rtal_defs.svh"
module tb_top;
   logic ref_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [5:0] strap_val, addr_out;
   logic [4:0] straps;
   logic parity, latch_pin, latch_req, msg, tmode, cmd, stat_n;
   int err_count = 0;
   int total_checks = 0;
   int lows;
   // The single slave's ready is the bus ready
   assign hready = hreadyout;
   rtal_strap_board board_u (.ref_clk(ref_clk), .strap_val(strap_val),
      .latch_req(latch_req), .straps(straps), .parity(parity),
      .latch_pin(latch_pin));
   rtal_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .terminal_address_straps(straps),
      .terminal_address_parity_strap(parity),
      .terminal_address_latch_pin(latch_pin), .message_active(msg),
      .terminal_mode(tmode), .reset_cmd_rx(cmd),
      .terminal_address_ff(addr_out), .status_out_n_ff(stat_n));
   // ==========================================================
   // Clock and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #50000;
      err_count++;
      summarize();
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // One single AHB transfer; called just after a rising edge
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask
   // Raise the command and count low cycles of the shared output
   task automatic pulse;
      cmd <= 1'b1;
      lows = 0;
      repeat (8) begin
         @(posedge ref_clk);
         if (stat_n === 1'b0) lows++;
      end
      cmd <= 1'b0;
      cyc(1);
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      reset_n = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      strap_val = 6'h2B;
      latch_req = 1'b0;
      msg = 1'b0;
      tmode = 1'b0;
      cmd = 1'b0;
      cyc(5);
      reset_n <= 1'b1;
      cyc(6);
      chk(32'(addr_out), 32'h2B);
      bus(1'b0, `RTAL_STAT_OFS, 32'h0);
      chk(rd, 32'h2B);
      latch_req <= 1'b1;
      cyc(6);
      strap_val <= 6'h14;
      cyc(6);
      chk(32'(addr_out), 32'h2B);
      $display("test strap latch done");
      bus(1'b1, `RTAL_CFG6_OFS, 32'h20);
      bus(1'b1, `RTAL_CFG5_OFS, 32'h1D);
      cyc(4);
      chk(32'(addr_out), 32'h2B);
      bus(1'b1, `RTAL_CFG4_OFS, 32'h8);
      bus(1'b1, `RTAL_CFG5_OFS, 32'h1D);
      cyc(4);
      chk(32'(addr_out), 32'h1D);
      bus(1'b0, `RTAL_CFG5_OFS, 32'h0);
      chk(rd, 32'h1D);
      bus(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      chk(32'(hresp), 32'h0);
      chk(32'(hreadyout), 32'h1);
      $display("test host address done");
      bus(1'b1, `RTAL_CFG7_OFS, 32'h0);
      msg <= 1'b1;
      cyc(3);
      chk(32'(stat_n), 32'h0);
      msg <= 1'b0;
      cyc(3);
      chk(32'(stat_n), 32'h1);
      bus(1'b1, `RTAL_CFG7_OFS, 32'h1);
      tmode <= 1'b1;
      msg <= 1'b1;
      pulse();
      chk(32'(lows), 32'h2);
      tmode <= 1'b0;
      pulse();
      chk(32'(lows), 32'h0);
      $display("test status output done");
      summarize();
   end
endmodule
